// ==== hw/rcs_defines.svh ====
// constant macros for the reader command sequencer
//
// Functional notes
// - host command write starts that command
// - arguments and data pass through shared FIFO
// - stream commands consume queued bytes immediately
// - argument commands wait for all argument bytes
// - command start never clears the FIFO
// - new command aborts any command except power-up
// - code 3Fh is reset then initialisation
// - power-up runs only after reset, never host
// - code 00h only cancels the running command
// - code 1Ah sends FIFO bytes to transmitter
// - code 16h waits guard delay, then receives
// - code 1Eh transmits, waits guard, then receives
// - code 01h takes address low, high, then data
// - self completion returns idle, raises done flag, except power-up
// - host idle abort: no done flag, FIFO kept
// - power-up ends in idle; host waits for it
// - transmit ends on byte request with FIFO empty
`ifndef RCS_DEFINES_SVH
`define RCS_DEFINES_SVH

`define RCS_CMD_W          6
`define RCS_CMD_IDLE       6'h00
`define RCS_CMD_EE_WRITE   6'h01
`define RCS_CMD_RECEIVE    6'h16
`define RCS_CMD_TRANSMIT   6'h1A
`define RCS_CMD_TRANSCEIVE 6'h1E
`define RCS_CMD_POWER_UP   6'h3F

`define RCS_FIFO_WIDTH     8
`define RCS_FIFO_DEPTH     32
`define RCS_GUARD_W        8

`define RCS_CLK_PERIOD_NS  100
`define RCS_RST_PHASE_NS   1000
`define RCS_RST_PHASE_CYC  ((`RCS_RST_PHASE_NS + `RCS_CLK_PERIOD_NS - 1) / `RCS_CLK_PERIOD_NS)
`define RCS_RST_CNT_W      4

`endif

// ==== hw/rcs_pkg.sv ====
// types shared by the reader command sequencer
package rcs_pkg;

	typedef enum logic [3:0] {
		RCS_ST_RESET,
		RCS_ST_INIT,
		RCS_ST_IDLE,
		RCS_ST_TX,
		RCS_ST_GUARD,
		RCS_ST_RX,
		RCS_ST_EE_LO,
		RCS_ST_EE_HI,
		RCS_ST_EE_DATA
	} rcs_state_t;

	typedef struct packed {
		logic       valid;
		logic       done;
		logic [7:0] data;
	} rcs_rx_t;

	typedef struct packed {
		logic        valid;
		logic [15:0] addr;
		logic [7:0]  data;
	} rcs_ee_t;

endpackage

// ==== hw/rcs_fifo.sv ====
// parameterised synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module rcs_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	input  wire logic             ref_clk,
	input  wire logic             sys_rst,
	input  wire logic             inValid,
	input  wire logic [WIDTH-1:0] inData,
	output logic                  inReady,
	output logic                  outValid,
	output logic      [WIDTH-1:0] outData,
	input  wire logic             outReady
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wrPtr_q;
	logic [AW:0]      rdPtr_q;
	logic             push;
	logic             pop;

	assign inReady  = (wrPtr_q - rdPtr_q) != (AW+1)'(DEPTH);
	assign outValid = wrPtr_q != rdPtr_q;
	assign outData  = mem[rdPtr_q[AW-1:0]];
	assign push     = inValid && inReady;
	assign pop      = outValid && outReady;

	always_ff @(posedge ref_clk) begin
		if (push) begin
			mem[wrPtr_q[AW-1:0]] <= inData;
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
		end else begin
			if (push) begin
				wrPtr_q <= wrPtr_q + 1'b1;
			end
			if (pop) begin
				rdPtr_q <= rdPtr_q + 1'b1;
			end
		end
	end
endmodule

// ==== hw/reader_command_sequencer.sv ====
// command sequencer of the contactless reader, with its shared FIFO
`timescale 1ns/1ps
`include "rcs_defines.svh"
module reader_command_sequencer
	import rcs_pkg::*;
(
	input  wire logic                       ref_clk,
	input  wire logic                       sys_rst,
	// host command port
	input  wire logic                       cmdWrEn,
	input  wire logic [`RCS_CMD_W-1:0]      cmdWrCode,
	output logic      [`RCS_CMD_W-1:0]      cmdActive,
	output logic                            commandDoneFlag,
	// host side of the shared FIFO
	input  wire logic                       hostWrValid,
	input  wire logic [`RCS_FIFO_WIDTH-1:0] hostWrData,
	output logic                            hostWrReady,
	output logic                            hostRdValid,
	output logic      [`RCS_FIFO_WIDTH-1:0] hostRdData,
	input  wire logic                       hostRdReady,
	// programmed receive guard delay, in clock cycles
	input  wire logic [`RCS_GUARD_W-1:0]    receiveGuardDelay,
	// initialisation phase handshake
	output logic                            initStart,
	input  wire logic                       initDone,
	// transmitter
	input  wire logic                       txReq,
	output logic                            txValid,
	output logic      [`RCS_FIFO_WIDTH-1:0] txData,
	output logic                            txActive,
	// receiver
	output logic                            rxEnable,
	input  wire rcs_rx_t                    rxIn,
	output logic                            rxReady,
	// eeprom write port
	output rcs_ee_t                         eeOut,
	input  wire logic                       eeReady
);
	// ==========================================================
	// declarations
	rcs_state_t                       state_q;
	rcs_state_t                       state_d;
	logic                             transceive_q;
	logic [`RCS_RST_CNT_W-1:0]        rstCnt_q;
	logic [`RCS_GUARD_W-1:0]          guardCnt_q;
	logic [7:0]                       eeAddrLo_q;
	logic [`RCS_CMD_W-1:0]            cmd_q;
	logic                             selfDone;
	logic                             hostCmd;
	logic                             fifoInValid;
	logic [`RCS_FIFO_WIDTH-1:0]       fifoInData;
	logic                             fifoInReady;
	logic                             fifoOutValid;
	logic [`RCS_FIFO_WIDTH-1:0]       fifoOutData;
	logic                             fifoOutReady;
	logic                             seqPop;
	logic                             seqReads;

	// decodes a written code into the state its command opens with
	function automatic rcs_state_t first_state(input logic [`RCS_CMD_W-1:0] code);
		unique case (code)
			`RCS_CMD_TRANSMIT:   first_state = RCS_ST_TX;
			`RCS_CMD_TRANSCEIVE: first_state = RCS_ST_TX;
			`RCS_CMD_RECEIVE:    first_state = RCS_ST_GUARD;
			`RCS_CMD_EE_WRITE:   first_state = RCS_ST_EE_LO;
			default:             first_state = RCS_ST_IDLE;
		endcase
	endfunction

	// codes outside the set read back as idle
	function automatic logic [`RCS_CMD_W-1:0] known_code(input logic [`RCS_CMD_W-1:0] code);
		known_code = (first_state(code) == RCS_ST_IDLE) ? `RCS_CMD_IDLE : code;
	endfunction

	// ==========================================================
	// shared FIFO
	// receiver owns the write side only while receiving
	assign fifoInValid = (state_q == RCS_ST_RX) ? rxIn.valid : hostWrValid;
	assign fifoInData  = (state_q == RCS_ST_RX) ? rxIn.data : hostWrData;
	assign hostWrReady = (state_q != RCS_ST_RX) && fifoInReady;
	assign rxReady     = (state_q == RCS_ST_RX) && fifoInReady;

	// the sequencer drains the FIFO in consuming states, the host otherwise
	assign seqReads = (state_q == RCS_ST_TX) || (state_q == RCS_ST_EE_LO) ||
	                  (state_q == RCS_ST_EE_HI) || (state_q == RCS_ST_EE_DATA);

	always_comb begin
		seqPop = 1'b0;
		unique case (state_q)
			RCS_ST_TX:      seqPop = txReq && fifoOutValid;
			RCS_ST_EE_LO:   seqPop = fifoOutValid;
			RCS_ST_EE_HI:   seqPop = fifoOutValid;
			// load whenever the hold slot is free, so valid never waits on ready
			RCS_ST_EE_DATA: seqPop = fifoOutValid && !eeOut.valid;
			default:        seqPop = 1'b0;
		endcase
	end

	assign fifoOutReady = seqReads ? seqPop : hostRdReady;
	assign hostRdValid  = !seqReads && fifoOutValid;
	assign hostRdData   = fifoOutData;

	// contents survive every command start and abort
	rcs_fifo #(
		.WIDTH (`RCS_FIFO_WIDTH),
		.DEPTH (`RCS_FIFO_DEPTH)
	) u_fifo (
		.ref_clk  (ref_clk),
		.sys_rst  (sys_rst),
		.inValid  (fifoInValid),
		.inData   (fifoInData),
		.inReady  (fifoInReady),
		.outValid (fifoOutValid),
		.outData  (fifoOutData),
		.outReady (fifoOutReady)
	);

	// ==========================================================
	// command state machine
	// host writes are ignored until power-up reaches idle
	assign hostCmd = cmdWrEn && (state_q != RCS_ST_RESET) && (state_q != RCS_ST_INIT);

	always_comb begin
		state_d  = state_q;
		selfDone = 1'b0;
		unique case (state_q)
			RCS_ST_RESET: begin
				if (rstCnt_q == `RCS_RST_CNT_W'(`RCS_RST_PHASE_CYC - 1)) begin
					state_d = RCS_ST_INIT;
				end
			end
			RCS_ST_INIT: begin
				if (initDone) begin
					state_d = RCS_ST_IDLE;
				end
			end
			RCS_ST_IDLE: begin
				state_d = RCS_ST_IDLE;
			end
			RCS_ST_TX: begin
				// empty FIFO on a byte request ends the send phase
				if (txReq && !fifoOutValid) begin
					if (transceive_q) begin
						state_d = RCS_ST_GUARD;
					end else begin
						state_d  = RCS_ST_IDLE;
						selfDone = 1'b1;
					end
				end
			end
			RCS_ST_GUARD: begin
				if (guardCnt_q >= receiveGuardDelay) begin
					state_d = RCS_ST_RX;
				end
			end
			RCS_ST_RX: begin
				if (rxIn.done) begin
					state_d  = RCS_ST_IDLE;
					selfDone = 1'b1;
				end
			end
			RCS_ST_EE_LO: begin
				if (fifoOutValid) begin
					state_d = RCS_ST_EE_HI;
				end
			end
			RCS_ST_EE_HI: begin
				if (fifoOutValid) begin
					state_d = RCS_ST_EE_DATA;
				end
			end
			RCS_ST_EE_DATA: begin
				// write finishes once the stream runs dry and the last byte left
				if (!fifoOutValid && !eeOut.valid) begin
					state_d  = RCS_ST_IDLE;
					selfDone = 1'b1;
				end
			end
			default: begin
				state_d = RCS_ST_IDLE;
			end
		endcase
		// a host write after power-up overrides whatever the machine was doing
		if (hostCmd) begin
			state_d  = first_state(cmdWrCode);
			selfDone = 1'b0;
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_q <= RCS_ST_RESET;
		end else begin
			state_q <= state_d;
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cmd_q        <= `RCS_CMD_POWER_UP;
			transceive_q <= 1'b0;
		end else if (hostCmd) begin
			cmd_q        <= known_code(cmdWrCode);
			transceive_q <= cmdWrCode == `RCS_CMD_TRANSCEIVE;
		end else if (state_d == RCS_ST_IDLE) begin
			cmd_q        <= `RCS_CMD_IDLE;
			transceive_q <= 1'b0;
		end
	end

	assign cmdActive = cmd_q;

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			commandDoneFlag <= 1'b0;
		end else begin
			commandDoneFlag <= selfDone;
		end
	end

	// ==========================================================
	// power-up phases
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rstCnt_q <= '0;
		end else if (state_q == RCS_ST_RESET) begin
			rstCnt_q <= rstCnt_q + 1'b1;
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			initStart <= 1'b0;
		end else begin
			initStart <= (state_q == RCS_ST_RESET) && (state_d == RCS_ST_INIT);
		end
	end

	// ==========================================================
	// receive guard delay
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			guardCnt_q <= '0;
		end else if (state_q != RCS_ST_GUARD || state_d != RCS_ST_GUARD) begin
			guardCnt_q <= '0;
		end else begin
			guardCnt_q <= guardCnt_q + 1'b1;
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rxEnable <= 1'b0;
		end else begin
			rxEnable <= state_d == RCS_ST_RX;
		end
	end

	// ==========================================================
	// transmitter byte delivery
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			txValid <= 1'b0;
			txData  <= 8'h00;
		end else begin
			txValid <= (state_q == RCS_ST_TX) && seqPop && !hostCmd;
			if ((state_q == RCS_ST_TX) && seqPop) begin
				txData <= fifoOutData;
			end
		end
	end

	// stops on the next cycle when the host writes any code other than 1Ah or 1Eh
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			txActive <= 1'b0;
		end else begin
			txActive <= state_d == RCS_ST_TX;
		end
	end

	// ==========================================================
	// eeprom write
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			eeAddrLo_q <= 8'h00;
		end else if (state_q == RCS_ST_EE_LO && seqPop) begin
			eeAddrLo_q <= fifoOutData;
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			eeOut <= '0;
		end else if (hostCmd) begin
			eeOut.valid <= 1'b0;
		end else begin
			if (state_q == RCS_ST_EE_HI && seqPop) begin
				eeOut.addr <= {fifoOutData, eeAddrLo_q};
			end
			if (state_q == RCS_ST_EE_DATA && seqPop) begin
				eeOut.valid <= 1'b1;
				eeOut.data  <= fifoOutData;
			end else if (eeOut.valid && eeReady) begin
				// address steps after each byte the eeprom takes
				eeOut.valid <= 1'b0;
				eeOut.addr  <= eeOut.addr + 16'h0001;
			end
		end
	end
endmodule

// ==== testbench/rcs_host_model.sv ====
// host partner model: command writes, FIFO pushes and pops
`timescale 1ns/1ps
module rcs_host_model (
	input  wire logic       ref_clk,
	output logic            cmdWrEn,
	output logic [5:0]      cmdWrCode,
	output logic            hostWrValid,
	output logic [7:0]      hostWrData,
	input  wire logic       hostWrReady,
	input  wire logic       hostRdValid,
	input  wire logic [7:0] hostRdData,
	output logic            hostRdReady
);
	initial begin
		cmdWrEn = 1'b0;
		cmdWrCode = 6'h00;
		hostWrValid = 1'b0;
		hostWrData = 8'h00;
		hostRdReady = 1'b0;
	end
	// =====================================
	// tasks, entered at a falling edge
	task automatic cmd(input logic [5:0] c);
		cmdWrEn = 1'b1;
		cmdWrCode = c;
		@(negedge ref_clk);
		cmdWrEn = 1'b0;
		@(negedge ref_clk);
	endtask
	// arguments and data only travel through the FIFO
	task automatic push(input logic [7:0] q[$]);
		foreach (q[i]) begin
			hostWrValid = 1'b1;
			hostWrData = q[i];
			while (!hostWrReady) @(negedge ref_clk);
			@(negedge ref_clk);
		end
		hostWrValid = 1'b0;
		// released data must not look valid
		hostWrData = ~hostWrData;
		@(negedge ref_clk);
	endtask
	task automatic pop(input int n, output logic [7:0] q[$]);
		q = {};
		hostRdReady = 1'b1;
		repeat (n) begin
			while (!hostRdValid) @(negedge ref_clk);
			q.push_back(hostRdData);
			@(negedge ref_clk);
		end
		hostRdReady = 1'b0;
		@(negedge ref_clk);
	endtask
endmodule

// ==== testbench/rcs_checker_sva.sv ====
// port assertions for the reader command sequencer
`timescale 1ns/1ps
`include "rcs_defines.svh"
module rcs_checker
	import rcs_pkg::*;
(
	input wire logic                    ref_clk,
	input wire logic                    sys_rst,
	input wire logic                    cmdWrEn,
	input wire logic [`RCS_CMD_W-1:0]   cmdWrCode,
	input wire logic [`RCS_CMD_W-1:0]   cmdActive,
	input wire logic                    commandDoneFlag,
	input wire logic [`RCS_GUARD_W-1:0] receiveGuardDelay,
	input wire logic                    initStart,
	input wire logic                    initDone,
	input wire logic                    txReq,
	input wire logic                    txValid,
	input wire logic                    txActive,
	input wire logic                    rxEnable,
	input wire rcs_rx_t                 rxIn,
	input wire rcs_ee_t                 eeOut,
	input wire logic                    eeReady
);
	logic [8:0] sinceCmd_q;
	// saturates so a long wait never wraps to a small count
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			sinceCmd_q <= 9'h000;
		end else if (cmdWrEn) begin
			sinceCmd_q <= 9'h000;
		end else if (sinceCmd_q != 9'h1FF) begin
			sinceCmd_q <= sinceCmd_q + 9'h001;
		end
	end
	// =====================================
	// assertions
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	a_cmd_taken: assert property (
		cmdWrEn && cmdActive != 6'h3F && cmdWrCode inside {6'h00, 6'h01, 6'h16, 6'h1A, 6'h1E}
		|=> cmdActive == $past(cmdWrCode)) else $error("command not taken");
	a_bad_code: assert property (
		cmdWrEn && cmdActive != 6'h3F && !(cmdWrCode inside {6'h01, 6'h16, 6'h1A, 6'h1E})
		|=> cmdActive == 6'h00) else $error("bad code not idle");
	a_powerup_lock: assert property (
		cmdActive == 6'h3F && cmdWrEn && !initDone |=> cmdActive == 6'h3F)
		else $error("power-up interrupted");
	a_abort_quiet: assert property (
		cmdWrEn && cmdActive != 6'h3F |=> !commandDoneFlag) else $error("abort flagged done");
	a_init_pulse: assert property (
		initStart |=> !initStart && cmdActive == 6'h3F) else $error("init pulse");
	a_tx_answer: assert property (
		txActive && txReq && !cmdWrEn |=> txValid || !txActive) else $error("tx no answer");
	a_tx_finish: assert property (
		$fell(txActive) && $past(cmdActive) == 6'h1A && !$past(cmdWrEn)
		|-> cmdActive == 6'h00 ##[0:1] commandDoneFlag) else $error("tx end");
	a_guard_wait: assert property (
		$rose(rxEnable) |-> sinceCmd_q > {1'b0, receiveGuardDelay}) else $error("guard short");
	a_rx_finish: assert property (
		rxEnable && rxIn.done && !cmdWrEn
		|=> !rxEnable && cmdActive == 6'h00 ##[0:1] commandDoneFlag) else $error("rx end");
	a_ee_hold: assert property (
		eeOut.valid && !eeReady && !cmdWrEn |=> eeOut.valid && $stable(eeOut))
		else $error("ee request dropped");
	a_ee_step: assert property (
		eeOut.valid && eeReady && !cmdWrEn
		|=> eeOut.addr == $past(eeOut.addr) + 16'h0001) else $error("ee address step");
endmodule
bind reader_command_sequencer rcs_checker i_rcs_checker (.ref_clk, .sys_rst, .cmdWrEn,
	.cmdWrCode, .cmdActive, .commandDoneFlag, .receiveGuardDelay, .initStart, .initDone,
	.txReq, .txValid, .txActive, .rxEnable, .rxIn, .eeOut, .eeReady);

// ==== testbench/tb.sv ====
// testbench for the reader command sequencer
`timescale 1ns/1ps
`include "rcs_defines.svh"
module tb
	import rcs_pkg::*;
;
	logic       ref_clk = 1'b0;
	logic       sys_rst = 1'b1;
	logic       cmdWrEn, hostWrValid, hostWrReady, hostRdValid, hostRdReady;
	logic       commandDoneFlag, initStart, initDone, txReq, txValid, txActive;
	logic       rxEnable, rxReady, eeReady;
	logic [5:0] cmdWrCode, cmdActive;
	logic [7:0] hostWrData, hostRdData, receiveGuardDelay, txData;
	rcs_rx_t    rxIn;
	rcs_ee_t    eeOut;
	logic [7:0] q[$];
	int         fail_count = 0;
	int         compares = 0;
	int         doneCnt = 0;
	int         cycles = 0;
	reader_command_sequencer i_reader_command_sequencer (.ref_clk, .sys_rst, .cmdWrEn,
		.cmdWrCode, .cmdActive, .commandDoneFlag, .hostWrValid, .hostWrData, .hostWrReady,
		.hostRdValid, .hostRdData, .hostRdReady, .receiveGuardDelay, .initStart, .initDone,
		.txReq, .txValid, .txData, .txActive, .rxEnable, .rxIn, .rxReady, .eeOut, .eeReady);
	rcs_host_model i_rcs_host_model (.ref_clk, .cmdWrEn, .cmdWrCode, .hostWrValid,
		.hostWrData, .hostWrReady, .hostRdValid, .hostRdData, .hostRdReady);
	always #50 ref_clk = ~ref_clk;
	// ceiling well above the few hundred cycles the run needs
	always @(posedge ref_clk) begin
		cycles++;
		if (commandDoneFlag === 1'b1) doneCnt++;
		if (cycles == 3000) begin
			fail_count++;
			wrap_up();
		end
	end
	// =====================================
	// helpers
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED %0t %s", $time, m);
		end
	endtask
	task automatic chk_q(input logic [7:0] g[$], input logic [7:0] e[$], input string m);
		chk(g.size(), e.size(), m);
		foreach (e[i]) chk(g[i], e[i], m);
	endtask
	task automatic wrap_up();
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic wait_rx(output int n);
		n = 0;
		while (rxEnable !== 1'b1 && n < 100) begin
			@(negedge ref_clk);
			n++;
		end
	endtask
	task automatic tx_req(input logic [7:0] e, input logic has);
		txReq = 1'b1;
		@(negedge ref_clk);
		txReq = 1'b0;
		chk(txValid, has, "tx valid");
		if (has) chk(txData, e, "tx data");
		@(negedge ref_clk);
	endtask
	task automatic rx_frame(input logic [7:0] b[$]);
		foreach (b[i]) begin
			rxIn = '{valid: 1'b1, done: 1'b0, data: b[i]};
			while (!rxReady) @(negedge ref_clk);
			@(negedge ref_clk);
		end
		rxIn.valid = 1'b0;
		rxIn.done = 1'b1;
		rxIn.data = ~rxIn.data;
		@(negedge ref_clk);
		rxIn.done = 1'b0;
		repeat (3) @(negedge ref_clk);
	endtask
	task automatic ee_take(input logic [15:0] a, input logic [7:0] d);
		int n;
		n = 0;
		while (eeOut.valid !== 1'b1 && n < 50) begin
			@(negedge ref_clk);
			n++;
		end
		repeat (2) @(negedge ref_clk);
		chk(eeOut.addr, a, "ee addr");
		chk(eeOut.data, d, "ee data");
		eeReady = 1'b1;
		@(negedge ref_clk);
		eeReady = 1'b0;
		@(negedge ref_clk);
	endtask
	// =====================================
	// scenarios
	task automatic t_power_up();
		int n;
		n = 0;
		chk(cmdActive, 6'h3F, "power-up code");
		while (initStart !== 1'b1 && n < 50) begin
			@(negedge ref_clk);
			n++;
		end
		chk(n >= 10 && n < 50, 1'b1, "reset phase");
		i_rcs_host_model.cmd(6'h1A);
		chk(cmdActive, 6'h3F, "power-up lock");
		initDone = 1'b1;
		@(negedge ref_clk);
		initDone = 1'b0;
		repeat (3) @(negedge ref_clk);
		chk(cmdActive, 6'h00, "idle after power-up");
	endtask
	task automatic t_transmit();
		int d;
		i_rcs_host_model.push('{8'hA1, 8'hB2, 8'hC3});
		i_rcs_host_model.cmd(6'h1A);
		chk(txActive, 1'b1, "tx active");
		d = doneCnt;
		tx_req(8'hA1, 1'b1);
		tx_req(8'hB2, 1'b1);
		tx_req(8'hC3, 1'b1);
		tx_req(8'h00, 1'b0);
		repeat (2) @(negedge ref_clk);
		chk(cmdActive, 6'h00, "tx idle");
		chk(doneCnt - d, 1, "tx done");
	endtask
	task automatic t_codes();
		logic [5:0] c[8] = '{6'h01, 6'h16, 6'h1A, 6'h1E, 6'h00, 6'h3F, 6'h2A, 6'h03};
		logic [5:0] e[8] = '{6'h01, 6'h16, 6'h1A, 6'h1E, 6'h00, 6'h00, 6'h00, 6'h00};
		int d;
		d = doneCnt;
		foreach (c[i]) begin
			i_rcs_host_model.cmd(c[i]);
			chk(cmdActive, e[i], "code");
		end
		i_rcs_host_model.push('{8'h5C, 8'h6D});
		i_rcs_host_model.cmd(6'h1A);
		i_rcs_host_model.cmd(6'h00);
		chk(doneCnt - d, 0, "abort done");
		i_rcs_host_model.pop(2, q);
		chk_q(q, '{8'h5C, 8'h6D}, "fifo kept");
	endtask
	// stand-alone receive, used here only as a
	task automatic t_receive();
		int d;
		int n;
		d = doneCnt;
		i_rcs_host_model.cmd(6'h16);
		chk(rxEnable, 1'b0, "guard");
		wait_rx(n);
		chk(n, receiveGuardDelay, "guard length");
		rx_frame('{8'h5A, 8'h3C});
		chk(cmdActive, 6'h00, "rx idle");
		chk(doneCnt - d, 1, "rx done");
		i_rcs_host_model.pop(2, q);
		chk_q(q, '{8'h5A, 8'h3C}, "rx bytes");
	endtask
	task automatic t_transceive();
		int d;
		int n;
		d = doneCnt;
		receiveGuardDelay = 8'h0A;
		i_rcs_host_model.push('{8'h77});
		i_rcs_host_model.cmd(6'h1E);
		tx_req(8'h77, 1'b1);
		tx_req(8'h00, 1'b0);
		chk(rxEnable, 1'b0, "trx guard");
		wait_rx(n);
		chk(n, receiveGuardDelay, "trx guard length");
		rx_frame('{8'hE1});
		chk(doneCnt - d, 1, "trx done");
		i_rcs_host_model.pop(1, q);
		chk_q(q, '{8'hE1}, "trx bytes");
	endtask
	task automatic t_eeprom();
		int d;
		d = doneCnt;
		i_rcs_host_model.push('{8'h10});
		i_rcs_host_model.cmd(6'h01);
		repeat (4) @(negedge ref_clk);
		chk(eeOut.valid, 1'b0, "ee early");
		i_rcs_host_model.push('{8'h02, 8'hD0, 8'hD1});
		ee_take(16'h0210, 8'hD0);
		ee_take(16'h0211, 8'hD1);
		repeat (3) @(negedge ref_clk);
		chk(cmdActive, 6'h00, "ee idle");
		chk(doneCnt - d, 1, "ee done");
	endtask
	task automatic t_fill();
		logic [7:0] b[$];
		for (int i = 0; i < 32; i++) b.push_back(8'(i * 7));
		i_rcs_host_model.push(b);
		chk(hostWrReady, 1'b0, "full");
		i_rcs_host_model.pop(32, q);
		chk_q(q, b, "drain");
		chk(hostRdValid, 1'b0, "empty");
	endtask
	// reset in mid-run aborts a send, empties the FIFO, reruns power-up
	task automatic t_rerun();
		i_rcs_host_model.push('{8'h99});
		i_rcs_host_model.cmd(6'h1A);
		sys_rst = 1'b1;
		repeat (2) @(negedge ref_clk);
		chk(cmdActive, 6'h3F, "reset code");
		chk(txActive, 1'b0, "reset tx");
		chk(hostRdValid, 1'b0, "reset fifo");
		sys_rst = 1'b0;
		t_power_up();
	endtask
	initial begin
		initDone = 1'b0;
		txReq = 1'b0;
		rxIn = '{default: 1'b0};
		eeReady = 1'b0;
		receiveGuardDelay = 8'h04;
		repeat (20) @(negedge ref_clk);
		sys_rst = 1'b0;
		t_power_up();
		t_transmit();
		t_codes();
		t_receive();
		t_transceive();
		t_eeprom();
		t_fill();
		t_rerun();
		wrap_up();
	end
endmodule
